// File: logic/lcd_com_seg_pin_control.sv
// lcd common/segment pin control with apb register access
`timescale 1ns/1ps
module lcd_com_seg_pin_control
    import lcd_pin_pkg::*;
#(
    parameter int NUM_LINES = NUM_SEG
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pin data from the shared i/o data registers
    input wire logic [NUM_LINES-1:0] pinData,
    // analog side
    output logic [1:0] biasCurrentSel,
    output logic [NUM_LINES-1:0] lcdPinSelect,
    output logic [2*NUM_LINES-1:0] pinLevel
);
    // the field map below is fixed at one line per enable bit
    if (NUM_LINES != NUM_SEG) begin : g_bad_lines
        $error("NUM_LINES must equal the number of lcd lines");
    end

    logic [7:0] ctrl0_q, ctrl0_d;
    logic [7:0] ctrl1_q, ctrl1_d;
    logic [7:0] ctrl2_q, ctrl2_d;
    logic [7:0] ctrl3_q, ctrl3_d;
    logic [7:0] ctrl4_q, ctrl4_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic [1:0] isel_q, isel_d;
    logic [NUM_LINES-1:0] pinSel_q, pinSel_d;
    logic [NUM_LINES-1:0] pinEn;
    logic [NUM_LINES-1:0] segMode;
    logic masterEn;
    logic frameOne;
    logic access;
    logic known;

    // true when the byte address hits a register
    function automatic logic addr_hit(input logic [11:0] a);
        return (a == OFF_CTRL0) || (a == OFF_CTRL1) || (a == OFF_CTRL2) ||
               (a == OFF_CTRL3) || (a == OFF_CTRL4);
    endfunction

    // one wait state: an access already answered is not taken again,
    // so a master that holds penable a cycle too long cannot write twice
    assign access = psel && penable && !pready_q;
    assign known = addr_hit(paddr);

    // register writes and single-wait-state apb answer
    always_comb begin
        ctrl0_d = ctrl0_q;
        ctrl1_d = ctrl1_q;
        ctrl2_d = ctrl2_q;
        ctrl3_d = ctrl3_q;
        ctrl4_d = ctrl4_q;
        prdata_d = prdata_q;
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        if (access) begin
            pready_d = 1'b1;
            pslverr_d = !known;
            prdata_d = 32'h0000_0000;
            if (pwrite) begin
                case (paddr)
                    OFF_CTRL0: ctrl0_d = pwdata[7:0];
                    OFF_CTRL1: ctrl1_d = pwdata[7:0];
                    OFF_CTRL2: ctrl2_d = pwdata[7:0];
                    OFF_CTRL3: ctrl3_d = pwdata[7:0];
                    OFF_CTRL4: ctrl4_d = pwdata[7:0] & CTRL4_MASK;
                    default: ctrl0_d = ctrl0_q;
                endcase
            end else begin
                case (paddr)
                    OFF_CTRL0: prdata_d = {24'h000000, ctrl0_q};
                    OFF_CTRL1: prdata_d = {24'h000000, ctrl1_q};
                    OFF_CTRL2: prdata_d = {24'h000000, ctrl2_q};
                    OFF_CTRL3: prdata_d = {24'h000000, ctrl3_q};
                    OFF_CTRL4: prdata_d = {24'h000000, ctrl4_q};
                    default: prdata_d = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl0_q <= RST_CTRL;
            ctrl1_q <= RST_CTRL;
            ctrl2_q <= RST_CTRL;
            ctrl3_q <= RST_CTRL;
            ctrl4_q <= RST_CTRL;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            ctrl0_q <= ctrl0_d;
            ctrl1_q <= ctrl1_d;
            ctrl2_q <= ctrl2_d;
            ctrl3_q <= ctrl3_d;
            ctrl4_q <= ctrl4_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // field decode
    // a shared pin keeps its other function unless enabled here
    assign masterEn = ctrl0_q[BIT_MASTER_EN];
    assign frameOne = ctrl0_q[BIT_FRAME];
    assign pinEn = {ctrl4_q[1:0], ctrl3_q, ctrl2_q,
                    ctrl1_q[BIT_COM5EN], ctrl1_q[BIT_COM4EN],
                    ctrl0_q[3:0]};
    // lines 6 and up are segment-only
    assign segMode = {{(NUM_LINES-NUM_SHARED){1'b1}},
                      ctrl1_q[NUM_SHARED-1:0]};

    // pin select and bias code registered for the pad mux
    // one cycle of latency buys a glitch-free switch at the pads
    always_comb begin
        isel_d = ctrl0_q[BIT_ISEL_HI:BIT_ISEL_LO];
        // gated by master enable; port direction is not consulted
        pinSel_d = masterEn ? pinEn : '0;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            isel_q <= ISEL_8U3;
            pinSel_q <= '0;
        end else begin
            isel_q <= isel_d;
            pinSel_q <= pinSel_d;
        end
    end

    assign biasCurrentSel = isel_q;
    assign lcdPinSelect = pinSel_q;

    // one level encoder per line
    // all encoders share frame and master enable, so lines flip together
    for (genvar i = 0; i < NUM_LINES; i++) begin : g_line
        lcd_level_encoder u_enc (
            .clk_sys(clk_sys),
            .rst(rst),
            .active(masterEn && pinEn[i]),
            .frameOne(frameOne),
            .isSegment(segMode[i]),
            .pinData(pinData[i]),
            .level_q(pinLevel[2*i+1:2*i])
        );
    end

    // assertions
    // level checks other than master_off_gnd_a skip the cycle after reset, where $past is stale
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    master_off_gnd_a: assert property (
        !$past(masterEn) |-> pinLevel == '0)
        else $error("lines not grounded while master enable off");

    pin_sel_gate_a: assert property (
        !rst |=> lcdPinSelect == ($past(masterEn) ? $past(pinEn) : '0))
        else $error("pin select not gated by master enable");

    upper_zero_a: assert property (
        ctrl4_q[7:2] == 6'h00)
        else $error("control four upper bits not zero");

    bias_follow_a: assert property (
        !rst |=> biasCurrentSel == $past(ctrl0_q[BIT_ISEL_HI:BIT_ISEL_LO]))
        else $error("bias code does not follow control zero");

    frame0_com_a: assert property (
        !$past(rst) && $past(masterEn && pinEn[0] && !frameOne && !segMode[0])
        |-> pinLevel[1:0] == ($past(pinData[0]) ? LVL_SUPPLY : LVL_THIRD))
        else $error("frame zero common level wrong");

    frame1_seg_a: assert property (
        !$past(rst) && $past(masterEn && pinEn[6] && frameOne)
        |-> pinLevel[13:12] == ($past(pinData[6]) ? LVL_THIRD : LVL_SUPPLY))
        else $error("frame one segment level wrong");

    apb_answer_a: assert property (
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("apb answer not one cycle");

    ctrl0_write_a: assert property (
        psel && penable && pwrite && !pready && paddr == OFF_CTRL0
        |=> ctrl0_q == $past(pwdata[7:0]))
        else $error("control zero write lost");

    // pin select follows each enable field, gated by the master bit
    shared_pin_sel_a: assert property (
        !rst |=> lcdPinSelect[3:0] ==
            ($past(masterEn) ? $past(ctrl0_q[3:0]) : 4'h0))
        else $error("shared pins 3..0 select wrong");

    upper_pin_sel_a: assert property (
        !rst |=> lcdPinSelect[5:4] == ($past(masterEn) ?
            $past({ctrl1_q[BIT_COM5EN], ctrl1_q[BIT_COM4EN]}) : 2'h0))
        else $error("shared pins 5..4 select wrong");

    seg_low_sel_a: assert property (
        !rst |=> lcdPinSelect[13:6] ==
            ($past(masterEn) ? $past(ctrl2_q) : 8'h00))
        else $error("segment lines 13..6 select wrong");

    seg_mid_sel_a: assert property (
        !rst |=> lcdPinSelect[21:14] ==
            ($past(masterEn) ? $past(ctrl3_q) : 8'h00))
        else $error("segment lines 21..14 select wrong");

    seg_high_sel_a: assert property (
        !rst |=> lcdPinSelect[23:22] ==
            ($past(masterEn) ? $past(ctrl4_q[1:0]) : 2'h0))
        else $error("segment lines 23..22 select wrong");

    master_clear_a: assert property (
        !rst && !masterEn |=> lcdPinSelect == '0)
        else $error("lines selected while master enable off");

    // the other frame on each watched line, and line 0 segment duty in frame one
    frame0_seg_a: assert property (
        !$past(rst) && $past(masterEn && pinEn[6] && !frameOne)
        |-> pinLevel[13:12] ==
            ($past(pinData[6]) ? LVL_TWO_THIRDS : LVL_GND))
        else $error("frame zero segment level wrong");

    frame1_com_a: assert property (
        !$past(rst) && $past(masterEn && pinEn[0] && frameOne && !segMode[0])
        |-> pinLevel[1:0] == ($past(pinData[0]) ? LVL_GND : LVL_TWO_THIRDS))
        else $error("frame one common level wrong");

    seg_choice_a: assert property (
        !$past(rst) && $past(masterEn && pinEn[0] && frameOne && segMode[0])
        |-> pinLevel[1:0] == ($past(pinData[0]) ? LVL_THIRD : LVL_SUPPLY))
        else $error("line 0 segment duty level wrong");

    // register writes and reads as the bus sees them
    ctrl1_write_a: assert property (
        psel && penable && pwrite && !pready && paddr == OFF_CTRL1
        |=> ctrl1_q == $past(pwdata[7:0]))
        else $error("control one write lost");

    ctrl2_write_a: assert property (
        psel && penable && pwrite && !pready && paddr == OFF_CTRL2
        |=> ctrl2_q == $past(pwdata[7:0]))
        else $error("control two write lost");

    ctrl3_write_a: assert property (
        psel && penable && pwrite && !pready && paddr == OFF_CTRL3
        |=> ctrl3_q == $past(pwdata[7:0]))
        else $error("control three write lost");

    ctrl4_write_a: assert property (
        psel && penable && pwrite && !pready && paddr == OFF_CTRL4
        |=> ctrl4_q == ($past(pwdata[7:0]) & CTRL4_MASK))
        else $error("control four write not masked");

    ctrl0_hold_a: assert property (
        !rst && !(psel && penable && pwrite && paddr == OFF_CTRL0)
        |=> $stable(ctrl0_q))
        else $error("control zero changed without a write");

    ctrl0_read_a: assert property (
        pready && !pwrite && paddr == OFF_CTRL0
        |-> prdata == {24'h000000, $past(ctrl0_q)})
        else $error("control zero read data wrong");

    ctrl4_read_a: assert property (
        pready && !pwrite && paddr == OFF_CTRL4
        |-> prdata[7:2] == 6'h00)
        else $error("control four upper bits read nonzero");

    // reference table for the 1/3-bias levels, kept apart from the encoder
    function automatic level_type level_code(input logic f, s, d);
        case ({f, s, d})
            3'h0: return LVL_THIRD;
            3'h1: return LVL_SUPPLY;
            3'h2: return LVL_GND;
            3'h3: return LVL_TWO_THIRDS;
            3'h4: return LVL_TWO_THIRDS;
            3'h5: return LVL_GND;
            3'h6: return LVL_SUPPLY;
            3'h7: return LVL_THIRD;
            default: return LVL_GND;
        endcase
    endfunction

    // every line grounds when unselected and follows the table otherwise
    for (genvar j = 0; j < NUM_LINES; j++) begin : g_line_chk
        line_off_gnd_a: assert property (
            !$past(rst) && !$past(masterEn && pinEn[j])
            |-> pinLevel[2*j+1:2*j] == LVL_GND)
            else $error("unselected line not grounded");

        line_level_a: assert property (
            !$past(rst) && $past(masterEn && pinEn[j])
            |-> pinLevel[2*j+1:2*j] ==
                $past(level_code(frameOne, segMode[j], pinData[j])))
            else $error("selected line level wrong");
    end

    cover_master_on_c: cover property (!masterEn ##1 masterEn);
    cover_frame_flip_c: cover property (masterEn && frameOne ##1 !frameOne);
    cover_bad_addr_c: cover property (pready && pslverr);
    cover_read_c: cover property (pready && !pslverr && prdata != 0);
    cover_all_sel_c: cover property (lcdPinSelect == '1);
endmodule // lcd_com_seg_pin_control

// File: logic/lcd_level_encoder.sv
// per-pin drive level encoder for one lcd line
`timescale 1ns/1ps
module lcd_level_encoder
    import lcd_pin_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // selection
    input wire logic active,
    input wire logic frameOne,
    input wire logic isSegment,
    input wire logic pinData,
    // drive level
    output logic [1:0] level_q
);
    logic [1:0] level_d;

    // pick one of the four 1/3-bias levels
    always_comb begin
        level_d = LVL_GND;
        if (!active) begin
            level_d = LVL_GND;
        end else if (!frameOne) begin
            if (!isSegment) begin
                level_d = pinData ? LVL_SUPPLY : LVL_THIRD;
            end else begin
                level_d = pinData ? LVL_TWO_THIRDS : LVL_GND;
            end
        end else begin
            if (!isSegment) begin
                level_d = pinData ? LVL_GND : LVL_TWO_THIRDS;
            end else begin
                level_d = pinData ? LVL_THIRD : LVL_SUPPLY;
            end
        end
    end

    // registered so the analog side sees a clean level
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            level_q <= LVL_GND;
        end else begin
            level_q <= level_d;
        end
    end
endmodule // lcd_level_encoder

// File: logic/lcd_pin_pkg.sv
// shared constants for the lcd common/segment pin control block
package lcd_pin_pkg;
    localparam int NUM_SHARED = 6;
    localparam int NUM_SEG = 24;
    localparam int REG_W = 8;
    localparam int NUM_REGS = 5;
    // register byte offsets on the apb bus
    localparam logic [11:0] OFF_CTRL0 = 12'h000;
    localparam logic [11:0] OFF_CTRL1 = 12'h004;
    localparam logic [11:0] OFF_CTRL2 = 12'h008;
    localparam logic [11:0] OFF_CTRL3 = 12'h00C;
    localparam logic [11:0] OFF_CTRL4 = 12'h010;
    // reset values
    localparam logic [7:0] RST_CTRL = 8'h00;
    // control zero fields
    localparam int BIT_FRAME = 7;
    localparam int BIT_ISEL_HI = 6;
    localparam int BIT_ISEL_LO = 5;
    localparam int BIT_MASTER_EN = 4;
    // control one fields
    localparam int BIT_COM5EN = 7;
    localparam int BIT_COM4EN = 6;
    // control four writable mask
    localparam logic [7:0] CTRL4_MASK = 8'h03;
    // bias current codes
    typedef enum logic [1:0] {
        ISEL_8U3 = 2'b00,
        ISEL_16U7 = 2'b01,
        ISEL_50U = 2'b10,
        ISEL_100U = 2'b11
    } bias_current_type;
    // drive levels handed to the analog driver
    typedef enum logic [1:0] {
        LVL_GND = 2'b00,
        LVL_THIRD = 2'b01,
        LVL_TWO_THIRDS = 2'b10,
        LVL_SUPPLY = 2'b11
    } level_type;
endpackage

// File: verif/lcd_panel_model.sv
// passive lcd panel model: one pixel across line 0 and line 6
`timescale 1ns/1ps
module lcd_panel_model (
    // drive levels and pin select from the block
    input wire logic [47:0] pinLevel,
    input wire logic [23:0] lcdPinSelect,
    // pixel state
    output logic pixelLit
);
    // lit only on a full-supply swing, lesser swings stay dark
    assign pixelLit = lcdPinSelect[0] && lcdPinSelect[6] &&
        ({pinLevel[1:0], pinLevel[13:12]} == 4'hC ||
         {pinLevel[1:0], pinLevel[13:12]} == 4'h3);
endmodule // lcd_panel_model

// File: verif/tb_top.sv
// self-checking bench for the lcd common/segment pin control
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
    failures++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb_top;
    import lcd_pin_pkg::*;
    logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, rerr;
    logic pixelLit;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [23:0] pinData, lcdPinSelect;
    logic [1:0] biasCurrentSel;
    logic [47:0] pinLevel;
    int failures, tests_run;

    lcd_com_seg_pin_control dut (.clk_sys(clk_sys), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pinData(pinData),
        .biasCurrentSel(biasCurrentSel), .lcdPinSelect(lcdPinSelect),
        .pinLevel(pinLevel));
    lcd_panel_model panel (.pinLevel(pinLevel),
        .lcdPinSelect(lcdPinSelect), .pixelLit(pixelLit));

    // 100 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // expected level: frame, segment duty, pin data
    function automatic logic [1:0] lvl(input logic f, s, d);
        if (s) return f ? (d ? 2'h1 : 2'h3) : (d ? 2'h2 : 2'h0);
        return f ? (d ? 2'h0 : 2'h2) : (d ? 2'h3 : 2'h1);
    endfunction

    // one apb transfer, held until pready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        `CHK("rdata", {24'h000000, e}, rdat)
    endtask

    task stop_test;
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task t_reset;
        for (int i = 0; i < 5; i++) rd(12'(4 * i), RST_CTRL);
        `CHK("select", 24'h000000, lcdPinSelect)
        `CHK("level", 48'h0, pinLevel)
    endtask

    task t_regs;
        for (int i = 0; i < 5; i++) apb(1'b1, 12'(4 * i), 8'hFF);
        for (int i = 0; i < 4; i++) rd(12'(4 * i), 8'hFF);
        rd(OFF_CTRL4, CTRL4_MASK);
        rd(12'h014, 8'h00);
        `CHK("slverr", 1'b1, rerr)
        `CHK("select", 24'hFFFFFF, lcdPinSelect)
        `CHK("bias", 2'h3, biasCurrentSel)
        `CHK("level", {24{2'h3}}, pinLevel)
        apb(1'b1, OFF_CTRL0, 8'hEF);
        repeat (2) @(posedge clk_sys);
        `CHK("select", 24'h000000, lcdPinSelect)
        `CHK("level", 48'h0, pinLevel)
    endtask

    task t_select;
        apb(1'b1, OFF_CTRL0, 8'h11);
        apb(1'b1, OFF_CTRL1, 8'h80);
        apb(1'b1, OFF_CTRL2, 8'h01);
        apb(1'b1, OFF_CTRL3, 8'h80);
        apb(1'b1, OFF_CTRL4, 8'hFE);
        repeat (2) @(posedge clk_sys);
        `CHK("select", 24'hA00061, lcdPinSelect)
        rd(OFF_CTRL4, 8'h02);
    endtask

    // every frame, duty and data combination, bias codes alongside
    task t_levels;
        for (int k = 0; k < 8; k++) begin
            pinData <= {24{k[0]}};
            apb(1'b1, OFF_CTRL1, {7'h60, k[1]});
            apb(1'b1, OFF_CTRL0, {k[2], k[1:0], 1'b1, 4'h1});
            repeat (2) @(posedge clk_sys);
            `CHK("bias", k[1:0], biasCurrentSel)
            `CHK("line0", lvl(k[2], k[1], k[0]), pinLevel[1:0])
            `CHK("line6", lvl(k[2], 1'b1, k[0]), pinLevel[13:12])
            `CHK("line1", 2'h0, pinLevel[3:2])
        end
        pinData <= 24'h000001;
        apb(1'b1, OFF_CTRL1, 8'hC0);
        apb(1'b1, OFF_CTRL0, 8'h11);
        repeat (2) @(posedge clk_sys);
        `CHK("pixel", 1'b1, pixelLit)
    endtask

    // main sequence, with a second reset in mid-run
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        pinData = 24'h000000;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset;
        t_regs;
        t_select;
        t_levels;
        @(posedge clk_sys);
        rst <= 1'b1;
        pinData <= 24'h000000;
        @(posedge clk_sys);
        rst <= 1'b0;
        t_reset;
        stop_test;
    end

    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        stop_test;
    end
endmodule // tb_top
